// ---- design/tbc_core.sv ----
`timescale 1ns/1ns
module tbc_core
  import tbc_pkg::*;
#(
  parameter logic [31:0] MISMATCH_CYCLES = MISMATCH_CYC,
  parameter logic [31:0] FLASH_CYCLES = FLASH_CYC,
  parameter logic [19:0] DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata_q,
  input wire logic leadSelIn,
  input wire logic handIn,
  input wire logic lowFlameIn,
  input wire logic btnUp,
  input wire logic btnDown,
  input wire tbc_burner_t burner,
  input wire tbc_peer_t peerRx,
  output tbc_peer_t peerTx_q,
  output tbc_mode_t mode_q,
  output logic [POS_W-1:0] posOut_q,
  output logic [VAL_W-1:0] loadIdx_q,
  output logic [VAL_W-1:0] setpointOut_q,
  output logic [VAL_W-1:0] actualOut_q,
  output logic demandClosed_q,
  output logic burnerStop_q,
  output logic commFault_q,
  output logic faultFlash_q,
  output logic leadActive_q,
  output logic seqEnable_q,
  output logic loadDetErr_q
);
  // ========================================================================
  // helpers
  function automatic logic [POS_W-1:0] clampPos(input logic [POS_W-1:0] p);
    clampPos = (p < POS_MIN) ? POS_MIN : ((p > POS_MAX) ? POS_MAX : p);
  endfunction : clampPos

  // ========================================================================
  // control registers
  tbc_ctrl_t ctrl_q;
  logic [POS_W-1:0] handPos_q;
  logic [POS_W-1:0] handPos_d;
  wire wrCtrl = regWr && (regAddr == REG_CTRL);
  wire wrHand = regWr && (regAddr == REG_HAND);
  wire isMaster = ctrl_q.boilerId[0];
  wire twinOn = (ctrl_q.twinMode == TWIN_LOCK) || (ctrl_q.twinMode == TWIN_FREE);
  wire lockMode = (ctrl_q.twinMode == TWIN_LOCK);
  wire slaveRole = twinOn && !isMaster;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= CTRL_RST;
    end
    else if (clkEn && wrCtrl)
    begin
      ctrl_q <= tbc_ctrl_t'(regWdata[CTRL_W-1:0]);
    end
  end

  // ========================================================================
  // input synchronise and debounce
  logic [2:0] rawIn;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] dbState_q;
  logic [DB_W-1:0] dbCnt_q [3];
  assign rawIn = {lowFlameIn, handIn, leadSelIn};

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else if (clkEn)
    begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
    end
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_db
    wire differ = (sync2_q[i] != dbState_q[i]);
    wire settled = (dbCnt_q[i] >= DEBOUNCE_CYCLES - 20'h1);
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        dbCnt_q[i] <= '0;
        dbState_q[i] <= 1'b0;
      end
      else if (clkEn)
      begin
        dbCnt_q[i] <= (differ && !settled) ? dbCnt_q[i] + 20'h1 : '0;
        if (differ && settled)
        begin
          dbState_q[i] <= sync2_q[i];
        end
      end
    end
  end

  // ========================================================================
  // mode selection
  wire ignoreHl = !isMaster && lockMode;
  wire leadEff = dbState_q[0] && (!twinOn || isMaster);
  wire handEff = dbState_q[1] && !ignoreHl;
  wire lfhEff = dbState_q[2] && !ignoreHl;
  wire firingNow = burner.firing && !burner.startup;
  tbc_mode_t mode_d;
  logic [POS_W-1:0] pos_d;
  assign mode_d = !firingNow ? MD_IDLE :
                  lfhEff ? MD_LOWFL :
                  handEff ? MD_HAND :
                  MD_AUTO;
  assign pos_d = (mode_d == MD_LOWFL) ? POS_MIN :
                 (mode_d == MD_HAND) ? handPos_d :
                 burner.pidPos;
  wire enterHand = (mode_d == MD_HAND) && (mode_q != MD_HAND);
  wire canUp = (mode_q == MD_HAND) && btnUp && (handPos_q < POS_MAX);
  wire canDn = (mode_q == MD_HAND) && btnDown && (handPos_q > POS_MIN);
  assign handPos_d = (enterHand && !ctrl_q.handKeep) ? clampPos(burner.ratePos) :
                     canUp ? handPos_q + POS_STEP :
                     canDn ? handPos_q - POS_STEP :
                     wrHand ? clampPos(regWdata[POS_W-1:0]) :
                     handPos_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= MD_IDLE;
      posOut_q <= POS_MIN;
      handPos_q <= HAND_RST;
      leadActive_q <= 1'b0;
      seqEnable_q <= 1'b1;
    end
    else if (clkEn)
    begin
      mode_q <= mode_d;
      posOut_q <= pos_d;
      handPos_q <= handPos_d;
      leadActive_q <= leadEff;
      seqEnable_q <= !(handEff || lfhEff);
    end
  end

  // ========================================================================
  // twin coordination
  wire twinLink = twinOn && peerRx.linkOk;
  wire phaseSkew = burner.startup && (burner.phase != peerRx.phase);
  wire modSkew = burner.modulating != peerRx.modulating;
  logic [CNT_W-1:0] misCnt_q;
  wire misTimeout = (misCnt_q >= MISMATCH_CYCLES);
  wire fault_d = lockMode && (!peerRx.linkOk || peerRx.error || misTimeout);
  wire baseDemand = (!isMaster && twinLink) ? peerRx.demand : burner.demand;
  wire demand_d = baseDemand && !fault_d;
  wire loadErr_d = burner.loadDetFault && !slaveRole;
  logic [CNT_W-1:0] flashCnt_q;
  wire flashWrap = (flashCnt_q >= FLASH_CYCLES - 32'h1);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      misCnt_q <= '0;
    end
    else if (clkEn)
    begin
      if (lockMode && twinLink && (modSkew || phaseSkew))
      begin
        misCnt_q <= misTimeout ? misCnt_q : misCnt_q + 32'h1;
      end
      else
      begin
        misCnt_q <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flashCnt_q <= '0;
      faultFlash_q <= 1'b0;
    end
    else if (clkEn)
    begin
      flashCnt_q <= (fault_d && !flashWrap) ? flashCnt_q + 32'h1 : '0;
      if (!fault_d)
      begin
        faultFlash_q <= 1'b0;
      end
      else if (flashWrap)
      begin
        faultFlash_q <= !faultFlash_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      demandClosed_q <= 1'b0;
      burnerStop_q <= 1'b0;
      commFault_q <= 1'b0;
      loadDetErr_q <= 1'b0;
      loadIdx_q <= '0;
      setpointOut_q <= '0;
      actualOut_q <= '0;
      peerTx_q <= '0;
    end
    else if (clkEn)
    begin
      demandClosed_q <= demand_d;
      burnerStop_q <= lockMode && peerRx.linkOk && peerRx.lockout;
      commFault_q <= fault_d;
      loadDetErr_q <= loadErr_d;
      loadIdx_q <= (!isMaster && twinLink) ? peerRx.loadIndex : burner.loadIndex;
      setpointOut_q <= (!isMaster && twinLink) ? peerRx.setpoint : burner.setpoint;
      actualOut_q <= (!isMaster && twinLink) ? peerRx.actual : burner.actual;
      peerTx_q <= '{linkOk: 1'b1, demand: demand_d, modulating: burner.modulating,
                    lockout: burner.lockout, error: burner.error || loadErr_d,
                    phase: burner.phase, loadIndex: burner.loadIndex,
                    setpoint: burner.setpoint, actual: burner.actual};
    end
  end

  // ========================================================================
  // register read port
  logic [DATA_W-1:0] rdMux;
  logic [DATA_W-1:0] statusWord;
  assign statusWord = {16'h0000, misTimeout, peerRx.linkOk, seqEnable_q, leadActive_q,
                       loadDetErr_q, burnerStop_q, commFault_q, demandClosed_q,
                       isMaster, 3'h0, mode_q};
  assign rdMux = (regAddr == REG_CTRL) ? {21'h000000, ctrl_q} :
                 (regAddr == REG_HAND) ? {24'h000000, handPos_q} :
                 (regAddr == REG_STATUS) ? statusWord :
                 (regAddr == REG_PEER) ? {peerRx.setpoint, peerRx.loadIndex} :
                 32'h00000000;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regRdata_q <= '0;
    end
    else if (clkEn)
    begin
      regRdata_q <= regRd ? rdMux : '0;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  even_lead_ignore_a: assert property (clkEn && twinOn && !isMaster |=> !leadActive_q)
    else $error("even unit acted on lead select");
  even_hl_ignore_a: assert property (clkEn && lockMode && !isMaster |=> mode_q != MD_HAND
      && mode_q != MD_LOWFL)
    else $error("even unit acted on hand or low flame input");
  slave_load_a: assert property (clkEn && !isMaster && twinLink |=>
      loadIdx_q == $past(peerRx.loadIndex))
    else $error("slave load index not taken from master");
  lock_linkloss_a: assert property (clkEn && lockMode && !peerRx.linkOk |=> !demandClosed_q
      && commFault_q)
    else $error("link loss did not open demand contact");
  free_linkloss_a: assert property (clkEn && ctrl_q.twinMode == TWIN_FREE && !peerRx.linkOk
      |=> demandClosed_q == $past(burner.demand))
    else $error("free twin mode did not run stand-alone");
  lockout_stop_a: assert property (clkEn && lockMode && peerRx.linkOk && peerRx.lockout
      |=> burnerStop_q)
    else $error("peer lockout did not stop burner");
  mismatch_open_a: assert property (clkEn && misTimeout && lockMode |=> !demandClosed_q)
    else $error("mismatch timeout left demand closed");
  even_loaddet_a: assert property (clkEn && slaveRole |=> !loadDetErr_q)
    else $error("even unit flagged load detector");
  idle_mode_a: assert property (clkEn && !firingNow |=> mode_q == MD_IDLE)
    else $error("hand or low flame active while not firing");
  lfh_priority_a: assert property (clkEn && firingNow && lfhEff |=> mode_q == MD_LOWFL
      && posOut_q == POS_MIN)
    else $error("low flame hold not applied");
  auto_pid_a: assert property (clkEn && firingNow && !lfhEff && !handEff |=>
      posOut_q == $past(burner.pidPos))
    else $error("automatic mode not following pid");
  seq_hold_a: assert property (clkEn && (handEff || lfhEff) |=> !seqEnable_q)
    else $error("sequencing not suspended");
  peer_error_a: assert property (clkEn && lockMode && peerRx.error |=> !demandClosed_q
      && commFault_q)
    else $error("peer error did not open demand contact");
  slave_demand_a: assert property (clkEn && !isMaster && twinLink && !fault_d |=>
      demandClosed_q == $past(peerRx.demand))
    else $error("slave demand contact not following master");
  hand_range_a: assert property (clkEn && mode_d == MD_HAND |=> posOut_q >= POS_MIN
      && posOut_q <= POS_MAX)
    else $error("hand position outside flame range");
  lfh_over_hand_a: assert property (clkEn && firingNow && lfhEff && handEff |=> mode_q == MD_LOWFL)
    else $error("hand won over low flame hold");
  flash_idle_a: assert property (clkEn && !fault_d |=> !faultFlash_q)
    else $error("fault flashing without a fault");
  stop_clear_a: assert property (clkEn && !lockMode |=> !burnerStop_q)
    else $error("burner stop outside locked twin mode");
  frozen_state_a: assert property (!clkEn |=> $stable(mode_q) && $stable(posOut_q))
    else $error("state moved with clock enable low");
endmodule : tbc_core

// ---- pkg/tbc_pkg.sv ----
// ==========================================================================
// twin burner coordination package
package tbc_pkg;
  // ========================================================================
  // timing
  localparam longint unsigned CLK_HZ = 64'h0ee6b280;
  localparam longint unsigned MISMATCH_S = 64'h0a;
  localparam longint unsigned FLASH_S = 64'h03;
  localparam longint unsigned DEBOUNCE_US = 64'h3e8;
  localparam logic [31:0] MISMATCH_CYC = 32'(MISMATCH_S * CLK_HZ);
  localparam logic [31:0] FLASH_CYC = 32'(FLASH_S * CLK_HZ);
  localparam logic [19:0] DEBOUNCE_CYC = 20'(DEBOUNCE_US * CLK_HZ / 64'hf4240);
  localparam int DB_W = 20;
  localparam int CNT_W = 32;
  // ========================================================================
  // register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HAND = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PEER = 8'h0c;
  localparam int CTRL_W = 11;
  localparam int POS_W = 8;
  localparam int VAL_W = 16;
  localparam int PH_W = 3;
  // ========================================================================
  // twin mode values and positions
  localparam logic [1:0] TWIN_OFF = 2'h0;
  localparam logic [1:0] TWIN_LOCK = 2'h1;
  localparam logic [1:0] TWIN_FREE = 2'h2;
  localparam logic [7:0] POS_MIN = 8'h10;
  localparam logic [7:0] POS_MAX = 8'hf0;
  localparam logic [7:0] POS_STEP = 8'h01;
  localparam logic [7:0] HAND_RST = 8'h10;
  // ========================================================================
  // types
  typedef enum logic [3:0] {
    MD_IDLE = 4'b0001,
    MD_AUTO = 4'b0010,
    MD_LOWFL = 4'b0100,
    MD_HAND = 4'b1000
  } tbc_mode_t;
  typedef struct packed {
    logic handKeep;
    logic [1:0] twinMode;
    logic [7:0] boilerId;
  } tbc_ctrl_t;
  localparam tbc_ctrl_t CTRL_RST = '{handKeep: 1'b0, twinMode: TWIN_OFF, boilerId: 8'h01};
  typedef struct packed {
    logic linkOk;
    logic demand;
    logic modulating;
    logic lockout;
    logic error;
    logic [PH_W-1:0] phase;
    logic [VAL_W-1:0] loadIndex;
    logic [VAL_W-1:0] setpoint;
    logic [VAL_W-1:0] actual;
  } tbc_peer_t;
  typedef struct packed {
    logic firing;
    logic startup;
    logic modulating;
    logic lockout;
    logic error;
    logic demand;
    logic loadDetFault;
    logic [PH_W-1:0] phase;
    logic [POS_W-1:0] pidPos;
    logic [POS_W-1:0] ratePos;
    logic [VAL_W-1:0] loadIndex;
    logic [VAL_W-1:0] setpoint;
    logic [VAL_W-1:0] actual;
  } tbc_burner_t;
endpackage : tbc_pkg

// ---- dv/tbc_peer_model.sv ----
`timescale 1ns/1ns
// ==========================================================================
// peer controller on the far side of the link
module tbc_peer_model
  import tbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic linkUp,
  input wire logic peerMod,
  input wire logic peerLock,
  input wire logic peerErr,
  input wire logic peerHold,
  input wire logic [VAL_W-1:0] peerLoad,
  input wire tbc_peer_t txIn,
  output tbc_peer_t peerRx
);
  // peer phase echoes ours while linkUp is high unless peerHold freezes it, so start-up stays in step
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      peerRx <= '0;
    else if (!linkUp)
      peerRx <= '{linkOk: 1'b0, demand: ~peerRx.demand, modulating: ~peerRx.modulating,
        lockout: ~peerRx.lockout, error: ~peerRx.error, phase: ~peerRx.phase,
        loadIndex: ~peerRx.loadIndex, setpoint: ~peerRx.setpoint, actual: ~peerRx.actual};
    else
      peerRx <= '{linkOk: 1'b1, demand: 1'b1, modulating: peerMod, lockout: peerLock,
        error: peerErr, phase: peerHold ? peerRx.phase : txIn.phase, loadIndex: peerLoad,
        setpoint: peerLoad + 16'h0100, actual: peerLoad + 16'h0200};
  end
endmodule : tbc_peer_model

// ---- dv/tbc_core_tb.sv ----
`timescale 1ns/1ns
// ==========================================================================
// self-checking bench for the coordination core
module tbc_core_tb;
  import tbc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n, clkEn, regWr, regRd, leadSelIn, handIn, lowFlameIn, btnUp, btnDown;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata_q, rdv;
  tbc_burner_t burner;
  tbc_peer_t peerRx, peerTx_q;
  tbc_mode_t mode_q;
  logic [POS_W-1:0] posOut_q;
  logic [VAL_W-1:0] loadIdx_q, setpointOut_q, actualOut_q, peerLoad;
  logic demandClosed_q, burnerStop_q, commFault_q, faultFlash_q, leadActive_q, seqEnable_q;
  logic loadDetErr_q, linkUp, peerMod, peerLock, peerErr, peerHold;
  int err_total = 0;
  int n_compared = 0;
  always #2 sys_clk = ~sys_clk;
  tbc_core #(.MISMATCH_CYCLES(32'h14), .FLASH_CYCLES(32'h8), .DEBOUNCE_CYCLES(20'h3)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
    .leadSelIn(leadSelIn), .handIn(handIn), .lowFlameIn(lowFlameIn), .btnUp(btnUp),
    .btnDown(btnDown), .burner(burner), .peerRx(peerRx), .peerTx_q(peerTx_q),
    .mode_q(mode_q), .posOut_q(posOut_q), .loadIdx_q(loadIdx_q),
    .setpointOut_q(setpointOut_q), .actualOut_q(actualOut_q),
    .demandClosed_q(demandClosed_q), .burnerStop_q(burnerStop_q), .commFault_q(commFault_q),
    .faultFlash_q(faultFlash_q), .leadActive_q(leadActive_q), .seqEnable_q(seqEnable_q),
    .loadDetErr_q(loadDetErr_q));
  tbc_peer_model peer_u (.sys_clk(sys_clk), .arst_n(arst_n), .linkUp(linkUp),
    .peerMod(peerMod), .peerLock(peerLock), .peerErr(peerErr), .peerLoad(peerLoad),
    .peerHold(peerHold), .txIn(peerTx_q), .peerRx(peerRx));
  // ========================================================================
  // helpers
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask : chkb
  task automatic chkm(input tbc_mode_t m, input string what);
    chk({28'h0, mode_q}, {28'h0, m}, what);
  endtask : chkm
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata_q;
  endtask : rd
  task automatic end_of_test;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // ========================================================================
  // scenarios
  task automatic t_regs;
    rd(REG_CTRL, rdv);
    chk(rdv, 32'h0000_0001, "ctrl reset");
    rd(REG_HAND, rdv);
    chk(rdv, 32'h0000_0010, "hand reset");
    wr(REG_HAND, 32'h0000_00ff);
    rd(REG_HAND, rdv);
    chk(rdv, 32'h0000_00f0, "hand clamp");
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(REG_HAND, 32'h0000_0020);
    clkEn <= 1'b1;
    rd(REG_HAND, rdv);
    chk(rdv, 32'h0000_00f0, "frozen write");
    rd(8'h10, rdv);
    chk(rdv, 32'h0, "unmapped read");
  endtask : t_regs
  task automatic t_modes;
    @(posedge sys_clk);
    burner.firing <= 1'b0;
    handIn <= 1'b1;
    settle(12);
    chkm(MD_IDLE, "hand while off");
    chkb(seqEnable_q, 1'b0, "seq with hand");
    @(posedge sys_clk);
    burner.firing <= 1'b1;
    settle(3);
    chkm(MD_HAND, "hand mode");
    chk(posOut_q, 8'h40, "hand entry pos");
    @(posedge sys_clk);
    btnUp <= 1'b1;
    @(posedge sys_clk);
    btnUp <= 1'b0;
    settle(3);
    chk(posOut_q, 8'h41, "button step");
    @(posedge sys_clk);
    btnDown <= 1'b1;
    @(posedge sys_clk);
    btnDown <= 1'b0;
    settle(3);
    chk(posOut_q, 8'h40, "button down");
    @(posedge sys_clk);
    lowFlameIn <= 1'b1;
    settle(12);
    chkm(MD_LOWFL, "lfh over hand");
    chk(posOut_q, POS_MIN, "lfh pos");
    @(posedge sys_clk);
    lowFlameIn <= 1'b0;
    handIn <= 1'b0;
    settle(12);
    chkm(MD_AUTO, "auto mode");
    chk(posOut_q, 8'h80, "pid pos");
    chkb(seqEnable_q, 1'b1, "seq in auto");
    @(posedge sys_clk);
    handIn <= 1'b1;
    @(posedge sys_clk);
    handIn <= 1'b0;
    settle(12);
    chkm(MD_AUTO, "glitch ignored");
    @(posedge sys_clk);
    lowFlameIn <= 1'b1;
    settle(12);
    chkm(MD_LOWFL, "lfh again");
    @(posedge sys_clk);
    lowFlameIn <= 1'b0;
    settle(12);
  endtask : t_modes
  task automatic t_even;
    wr(REG_CTRL, 32'h0000_0102);
    @(posedge sys_clk);
    leadSelIn <= 1'b1;
    handIn <= 1'b1;
    burner.loadDetFault <= 1'b1;
    burner.demand <= 1'b0;
    burner.ratePos <= 8'h60;
    settle(12);
    chk(loadIdx_q, 16'h0abc, "load index");
    chk(setpointOut_q, 16'h0bbc, "setpoint");
    chk(actualOut_q, 16'h0cbc, "actual");
    chkb(demandClosed_q, 1'b1, "demand follows");
    chkb(leadActive_q, 1'b0, "lead ignored");
    chkm(MD_AUTO, "hand ignored");
    chkb(loadDetErr_q, 1'b0, "no load check");
    wr(REG_CTRL, 32'h0000_0602);
    settle(3);
    chkm(MD_HAND, "hand in mode 2");
    chk(posOut_q, 8'h40, "stored hand pos");
    chk(loadIdx_q, 16'h0abc, "load while hand");
    wr(REG_CTRL, 32'h0000_0001);
    settle(3);
    chkb(loadDetErr_q, 1'b1, "master load check");
    chkb(leadActive_q, 1'b1, "lead accepted");
    chkb(peerTx_q.error, 1'b1, "own error sent");
    chk(loadIdx_q, 16'h0123, "master own load");
    @(posedge sys_clk);
    leadSelIn <= 1'b0;
    handIn <= 1'b0;
    burner.loadDetFault <= 1'b0;
    burner.demand <= 1'b1;
    settle(12);
  endtask : t_even
  task automatic t_link;
    int k;
    wr(REG_CTRL, 32'h0000_0101);
    settle(3);
    chkb(demandClosed_q, 1'b1, "demand closed");
    chk(peerTx_q.loadIndex, 16'h0123, "load sent");
    chkb(peerTx_q.demand, 1'b1, "demand sent");
    rd(REG_STATUS, rdv);
    chk(rdv, 32'h0000_6182, "status word");
    rd(REG_PEER, rdv);
    chk(rdv, 32'h0bbc_0abc, "peer word");
    @(posedge sys_clk);
    linkUp <= 1'b0;
    settle(3);
    chkb(demandClosed_q, 1'b0, "link loss opens");
    chkb(commFault_q, 1'b1, "link loss fault");
    rdv[0] = faultFlash_q;
    for (k = 0; k < 12 && faultFlash_q === rdv[0]; k++)
      settle(1);
    chkb(faultFlash_q, ~rdv[0], "flash toggles");
    rdv[0] = faultFlash_q;
    for (k = 0; k < 12 && faultFlash_q === rdv[0]; k++)
      settle(1);
    chk(k, 8, "flash period");
    wr(REG_CTRL, 32'h0000_0201);
    settle(3);
    chkb(demandClosed_q, 1'b1, "stand-alone");
    chkb(commFault_q, 1'b0, "no fault mode 2");
    @(posedge sys_clk);
    linkUp <= 1'b1;
    wr(REG_CTRL, 32'h0000_0101);
    settle(3);
  endtask : t_link
  task automatic t_peer;
    @(posedge sys_clk);
    peerLock <= 1'b1;
    settle(3);
    chkb(burnerStop_q, 1'b1, "peer lockout");
    @(posedge sys_clk);
    peerLock <= 1'b0;
    peerErr <= 1'b1;
    settle(3);
    chkb(demandClosed_q, 1'b0, "peer error opens");
    chkb(commFault_q, 1'b1, "peer error fault");
    @(posedge sys_clk);
    peerErr <= 1'b0;
    peerMod <= 1'b0;
    settle(21);
    chkb(demandClosed_q, 1'b1, "mismatch early");
    settle(1);
    chkb(demandClosed_q, 1'b0, "mismatch timeout");
    @(posedge sys_clk);
    peerMod <= 1'b1;
    settle(3);
    @(posedge sys_clk);
    peerMod <= 1'b0;
    settle(10);
    @(posedge sys_clk);
    peerMod <= 1'b1;
    settle(15);
    chkb(demandClosed_q, 1'b1, "peer back in window");
    @(posedge sys_clk);
    peerHold <= 1'b1;
    burner.startup <= 1'b1;
    burner.phase <= 3'h2;
    settle(12);
    chkm(MD_IDLE, "idle in start-up");
    settle(12);
    chkb(demandClosed_q, 1'b0, "phase skew timeout");
    @(posedge sys_clk);
    peerHold <= 1'b0;
    burner.startup <= 1'b0;
    burner.phase <= 3'h5;
    settle(3);
  endtask : t_peer
  // ========================================================================
  // main sequence and watchdog
  initial
  begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    {regWr, regRd, leadSelIn, handIn, lowFlameIn, btnUp, btnDown} = 7'h0;
    regAddr = 8'h0;
    regWdata = 32'h0;
    burner = '0;
    burner.firing = 1'b1;
    burner.modulating = 1'b1;
    burner.demand = 1'b1;
    burner.phase = 3'h5;
    burner.pidPos = 8'h80;
    burner.ratePos = 8'h40;
    {linkUp, peerMod, peerLock, peerErr} = 4'hc;
    peerLoad = 16'h0abc;
    peerHold = 1'b0;
    burner.loadIndex = 16'h0123;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_modes();
    t_even();
    t_link();
    t_peer();
    end_of_test();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
endmodule : tbc_core_tb
